// >>> cfg_tail_pkg.sv
// Constants and carriers for the upper configuration header block.
package cfg_tail_pkg;

  // Configuration request from the bus core, taken in one clock cycle.
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] offset;
    logic [3:0] byte_en;
    logic [31:0] wdata;
  } cfg_req_t;

  // Configuration answer, registered, one cycle after the request.
  typedef struct packed {
    logic ack;
    logic hit;
    logic [31:0] rdata;
  } cfg_rsp_t;

  // Dword offsets inside configuration space.
  localparam logic [7:0] OFF_ROM_BASE = 8'h30;
  localparam logic [7:0] OFF_CAP_PTR = 8'h34;
  localparam logic [7:0] OFF_HOLE = 8'h38;
  localparam logic [7:0] OFF_IRQ_DWORD = 8'h3c;

  // Byte offsets of the four bytes of the interrupt dword.
  localparam logic [7:0] OFF_IRQ_ROUTING = 8'h3c;
  localparam logic [7:0] OFF_IRQ_PIN = 8'h3d;
  localparam logic [7:0] OFF_MIN_GRANT = 8'h3e;
  localparam logic [7:0] OFF_MAX_LATENCY = 8'h3f;

  // Span of this block in configuration space.
  localparam logic [7:0] TAIL_FIRST = 8'h30;
  localparam logic [7:0] TAIL_LAST = 8'h3f;

  // ROM base register layout.
  localparam int ROM_EN_BIT = 0;
  localparam int ROM_BASE_LSB = 11;
  localparam int ROM_BASE_W = 21;
  localparam logic [9:0] ROM_RSVD_VALUE = 10'h000;
  localparam logic ROM_EN_RESET = 1'b0;
  localparam logic ROM_EN_HELD = 1'b0;
  localparam logic [7:0] ROM_BYTE1_MASK = 8'hf8;
  localparam logic [7:0] ROM_BYTE_FULL_MASK = 8'hff;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // Fixed read values.
  localparam logic [7:0] CAP_PTR_VALUE = 8'h78;
  localparam logic [23:0] CAP_RSVD_VALUE = 24'h000000;
  localparam logic [7:0] IRQ_ROUTING_RESET = 8'h00;
  localparam logic [7:0] IRQ_PIN_VALUE = 8'h01;
  localparam logic [7:0] MIN_GRANT_VALUE = 8'h00;
  localparam logic [7:0] MAX_LATENCY_VALUE = 8'h00;
  localparam logic [31:0] ZERO_WORD = 32'h00000000;

  // Unit of the grant and latency bytes, and its count at the 200 MHz clock.
  localparam int CLK_PERIOD_PS = 5000;
  localparam int GRANT_UNIT_PS = 250000;
  localparam int GRANT_UNIT_CYCLES = GRANT_UNIT_PS / CLK_PERIOD_PS;

endpackage : cfg_tail_pkg

// >>> cfg_byte_field.sv
// One writable configuration byte with a per-bit write mask.
`timescale 1ns/100ps
module cfg_byte_field
  import cfg_tail_pkg::*;
#(
  parameter logic [7:0] WMASK = 8'hff,
  parameter logic [7:0] RESET_VALUE = 8'h00
) (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic wr_en_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] value_out
);

  // Stored byte; bits outside the mask never change.
  logic [7:0] value_q;
  logic [7:0] value_d;

  // Masked bits take the new data, the others keep their reset value.
  always_comb begin
    value_d = value_q;
    if (wr_en_in) begin
      value_d = (wdata_in & WMASK) | (RESET_VALUE & ~WMASK);
    end
  end

  // The byte returns to its reset value on the bus reset.
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      value_q <= RESET_VALUE;
    end else begin
      value_q <= value_d;
    end
  end

  assign value_out = value_q;

endmodule : cfg_byte_field

// >>> pci_config_header_tail.sv
// Upper configuration header: ROM window base, capability pointer, interrupt bytes.
//
// Operation
// - ROM decode enable bit, read-only, resets zero.
// - ROM claims need decode enable and range bit.
// - Decode enable held zero; no ROM present.
// - ROM base bits 31:11 writable; 10:1 zero.
// - Capability pointer reads 0x78; writes ignored.
// - Interrupt routing byte read-write, resets zero.
// - Interrupt pin byte reads one, read-only.
// - Minimum grant byte reads zero, read-only.
// - Maximum latency byte reads zero, read-only.
`timescale 1ns/100ps
module pci_config_header_tail
  import cfg_tail_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire cfg_req_t cfg_req_in,
  output cfg_rsp_t cfg_rsp_out,
  input wire logic local_rom_range_in,
  input wire logic mem_valid_in,
  input wire logic [31:0] mem_addr_in,
  output logic rom_claim_out,
  output logic rom_decode_enable_out,
  output logic [7:0] interrupt_routing_out
);

  // Request decode.
  logic req_is_write; // A configuration write is presented this cycle.
  logic req_is_read; // A configuration read is presented this cycle.
  logic sel_rom; // The request targets the ROM base dword.
  logic sel_irq; // The request targets the interrupt dword.
  logic in_tail; // The request lies in this block's span.

  // Register state.
  logic rom_en_q; // Decode enable of the ROM window.
  logic [ROM_BASE_W-1:0] rom_base; // Base address bits 31:11.
  logic [7:0] rom_byte1; // Bits 15:8 of the ROM base register.
  logic [7:0] rom_byte2; // Bits 23:16 of the ROM base register.
  logic [7:0] rom_byte3; // Bits 31:24 of the ROM base register.
  logic [7:0] irq_routing; // Interrupt routing byte.

  // Answer path.
  logic [31:0] rdata_d; // Read value chosen by the offset.
  cfg_rsp_t rsp_d;
  cfg_rsp_t rsp_q;

  // Window decode.
  logic rom_match; // Address falls inside the ROM window.
  logic rom_claim_d;
  logic rom_claim_q;

  // The dword is chosen by offset bits 7:2; low bits are a byte position only.
  always_comb begin
    req_is_write = cfg_req_in.valid && cfg_req_in.write;
    req_is_read = cfg_req_in.valid && !cfg_req_in.write;
    sel_rom = cfg_req_in.offset[7:2] == OFF_ROM_BASE[7:2];
    sel_irq = cfg_req_in.offset[7:2] == OFF_IRQ_DWORD[7:2];
    in_tail = (cfg_req_in.offset >= TAIL_FIRST) && (cfg_req_in.offset <= TAIL_LAST);
  end

  // The decode enable has no write path from the bus and stays at its held value.
  // Keeping a flop rather than a constant leaves room to tie it elsewhere later.
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rom_en_q <= ROM_EN_RESET;
    end else begin
      rom_en_q <= ROM_EN_HELD;
    end
  end

  // ROM base byte 1 holds bits 15:11; bits 10:8 are masked to zero.
  cfg_byte_field #(
    .WMASK(ROM_BYTE1_MASK),
    .RESET_VALUE(BYTE_RESET)
  ) u_rom_byte1 (
    .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .wr_en_in(req_is_write && sel_rom && cfg_req_in.byte_en[1]),
    .wdata_in(cfg_req_in.wdata[15:8]),
    .value_out(rom_byte1)
  );

  // ROM base byte 2 holds bits 23:16.
  cfg_byte_field #(
    .WMASK(ROM_BYTE_FULL_MASK),
    .RESET_VALUE(BYTE_RESET)
  ) u_rom_byte2 (
    .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .wr_en_in(req_is_write && sel_rom && cfg_req_in.byte_en[2]),
    .wdata_in(cfg_req_in.wdata[23:16]),
    .value_out(rom_byte2)
  );

  // ROM base byte 3 holds bits 31:24.
  cfg_byte_field #(
    .WMASK(ROM_BYTE_FULL_MASK),
    .RESET_VALUE(BYTE_RESET)
  ) u_rom_byte3 (
    .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .wr_en_in(req_is_write && sel_rom && cfg_req_in.byte_en[3]),
    .wdata_in(cfg_req_in.wdata[31:24]),
    .value_out(rom_byte3)
  );

  // Byte 0 of the ROM register is read-only, so lane 0 writes there do nothing.
  assign rom_base = {rom_byte3, rom_byte2, rom_byte1[7:3]};

  // Routing byte takes only lane 0; the other three lanes are read-only bytes.
  cfg_byte_field #(
    .WMASK(ROM_BYTE_FULL_MASK),
    .RESET_VALUE(IRQ_ROUTING_RESET)
  ) u_irq_routing (
    .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .wr_en_in(req_is_write && sel_irq && cfg_req_in.byte_en[0]),
    .wdata_in(cfg_req_in.wdata[7:0]),
    .value_out(irq_routing)
  );

  // Read multiplexer; unused and reserved places read as zero.
  always_comb begin
    rdata_d = ZERO_WORD;
    if (sel_rom) begin
      // Reserved bits 10:1 are constant zero.
      rdata_d = {rom_base, ROM_RSVD_VALUE, rom_en_q};
    end else if (cfg_req_in.offset[7:2] == OFF_CAP_PTR[7:2]) begin
      rdata_d = {CAP_RSVD_VALUE, CAP_PTR_VALUE};
    end else if (sel_irq) begin
      rdata_d = {MAX_LATENCY_VALUE, MIN_GRANT_VALUE, IRQ_PIN_VALUE, irq_routing};
    end else begin
      // The hole at the dword between pointer and interrupt bytes reads zero.
      rdata_d = ZERO_WORD;
    end
  end

  // Every request is acknowledged; hit says whether this block owns it.
  always_comb begin
    rsp_d.ack = cfg_req_in.valid;
    rsp_d.hit = cfg_req_in.valid && in_tail;
    if (req_is_read && in_tail) begin
      rsp_d.rdata = rdata_d;
    end else begin
      // Writes and foreign offsets answer with zero data.
      rsp_d.rdata = ZERO_WORD;
    end
  end

  // The answer is registered so data never ripples from the request pins.
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= rsp_d;
    end
  end

  // A 2 KB window at the programmed base.
  always_comb begin
    rom_match = mem_addr_in[31:ROM_BASE_LSB] == rom_base;
    rom_claim_d = mem_valid_in && rom_en_q && local_rom_range_in && rom_match;
  end

  // Claim is registered; both enables must permit it in the same cycle.
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rom_claim_q <= 1'b0;
    end else begin
      rom_claim_q <= rom_claim_d;
    end
  end

  // Outputs come straight from flops.
  assign cfg_rsp_out = rsp_q;
  assign rom_claim_out = rom_claim_q;
  assign rom_decode_enable_out = rom_en_q;
  assign interrupt_routing_out = irq_routing;

  // Checks, all on the bus clock and reset.
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!resetn_in);

  // A read of a given dword of this block.
  sequence s_read_rom;
    req_is_read && sel_rom;
  endsequence

  sequence s_read_cap;
    req_is_read && (cfg_req_in.offset[7:2] == OFF_CAP_PTR[7:2]);
  endsequence

  sequence s_read_irq;
    req_is_read && sel_irq;
  endsequence

  // An answer that carries a hit.
  sequence s_hit_answer;
    cfg_rsp_out.ack && cfg_rsp_out.hit;
  endsequence

  // Decode enable cannot be set from the bus, even by a full write of ones.
  property p_rom_en_locked;
    (req_is_write && sel_rom && cfg_req_in.byte_en[0] && cfg_req_in.wdata[0])
      |=> !rom_decode_enable_out ##1 !rom_decode_enable_out;
  endproperty
  a_rom_en_locked: assert property (p_rom_en_locked)
    else $error("ROM decode enable changed after a bus write");

  // No claim is made unless both enables allowed it one cycle before.
  property p_claim_qualified;
    rom_claim_out |-> $past(rom_en_q && local_rom_range_in && mem_valid_in);
  endproperty
  a_claim_qualified: assert property (p_claim_qualified)
    else $error("ROM claim without both decode enables");

  // A full write to the base dword appears in the upper 21 bits.
  property p_rom_base_write;
    (req_is_write && sel_rom && (cfg_req_in.byte_en == 4'hf))
      |=> rom_base == $past(cfg_req_in.wdata[31:ROM_BASE_LSB]);
  endproperty
  a_rom_base_write: assert property (p_rom_base_write)
    else $error("ROM base bits did not take the written value");

  // Reads of the ROM register show zeros in the reserved field.
  property p_rom_rsvd_zero;
    s_read_rom |=> s_hit_answer ##0 (cfg_rsp_out.rdata[10:1] == ROM_RSVD_VALUE);
  endproperty
  a_rom_rsvd_zero: assert property (p_rom_rsvd_zero)
    else $error("ROM reserved bits read non-zero");

  // The capability pointer reads its fixed offset one cycle later.
  property p_cap_read;
    s_read_cap |=> s_hit_answer ##0 (cfg_rsp_out.rdata == {CAP_RSVD_VALUE, CAP_PTR_VALUE});
  endproperty
  a_cap_read: assert property (p_cap_read)
    else $error("Capability pointer read wrong value");

  // A lane 0 write lands in the routing byte on the next edge.
  property p_routing_write;
    (req_is_write && sel_irq && cfg_req_in.byte_en[0])
      |=> interrupt_routing_out == $past(cfg_req_in.wdata[7:0]);
  endproperty
  a_routing_write: assert property (p_routing_write)
    else $error("Routing byte did not take the written value");

  // The three fixed bytes of the interrupt dword read their constants.
  property p_irq_fixed_bytes;
    s_read_irq |=> s_hit_answer
      ##0 (cfg_rsp_out.rdata[31:8] == {MAX_LATENCY_VALUE, MIN_GRANT_VALUE, IRQ_PIN_VALUE});
  endproperty
  a_irq_fixed_bytes: assert property (p_irq_fixed_bytes)
    else $error("Pin, grant or latency byte read wrong value");

  // A write to the interrupt dword without lane 0 leaves the routing byte alone.
  property p_lane_isolation;
    (req_is_write && sel_irq && !cfg_req_in.byte_en[0]) |=> $stable(interrupt_routing_out);
  endproperty
  a_lane_isolation: assert property (p_lane_isolation)
    else $error("Routing byte changed without its byte enable");

  // A read of the routing byte returns the value held when it was asked.
  property p_routing_readback;
    s_read_irq |=> cfg_rsp_out.rdata[7:0] == $past(irq_routing);
  endproperty
  a_routing_readback: assert property (p_routing_readback)
    else $error("Routing byte read back wrong value");

  // Every request is answered on the next edge, whether this block owns it or not.
  property p_ack_next;
    cfg_req_in.valid |=> cfg_rsp_out.ack;
  endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("Configuration request was not acknowledged");

  // Offsets outside this block answer without a hit and with zero data.
  property p_foreign_miss;
    (cfg_req_in.valid && !in_tail)
      |=> !cfg_rsp_out.hit && (cfg_rsp_out.rdata == ZERO_WORD);
  endproperty
  a_foreign_miss: assert property (p_foreign_miss)
    else $error("Foreign offset answered with a hit or data");

  // Writes answer with zero data, so a host never takes them for read data.
  property p_write_no_data;
    req_is_write |=> cfg_rsp_out.rdata == ZERO_WORD;
  endproperty
  a_write_no_data: assert property (p_write_no_data)
    else $error("Write answered with non-zero data");

  // Lane 0 of the ROM register is read-only, so a write on that lane alone changes nothing.
  property p_rom_lane0_ignored;
    (req_is_write && sel_rom && (cfg_req_in.byte_en == 4'h1)) |=> $stable(rom_base);
  endproperty
  a_rom_lane0_ignored: assert property (p_rom_lane0_ignored)
    else $error("ROM base changed on a lane 0 write");

  // A lane 3 write lands in the top byte of the base whatever the other lanes do.
  property p_rom_lane3_write;
    (req_is_write && sel_rom && cfg_req_in.byte_en[3])
      |=> rom_base[ROM_BASE_W-1:ROM_BASE_W-8] == $past(cfg_req_in.wdata[31:24]);
  endproperty
  a_rom_lane3_write: assert property (p_rom_lane3_write)
    else $error("ROM base top byte did not take the written value");

  // With no ROM fitted the window is never claimed, whatever address is probed.
  property p_no_claim;
    mem_valid_in |=> !rom_claim_out;
  endproperty
  a_no_claim: assert property (p_no_claim)
    else $error("ROM window claimed although no ROM is fitted");

endmodule : pci_config_header_tail

// >>> cfg_host_model.sv
// Host bridge and boot firmware model that issues configuration cycles and memory probes.
`timescale 1ns/100ps
module cfg_host_model
  import cfg_tail_pkg::*;
(
  input wire logic ref_clk_in,
  input wire cfg_rsp_t cfg_rsp_in,
  input wire logic rom_claim_in,
  output cfg_req_t cfg_req_out,
  output logic local_rom_range_out,
  output logic mem_valid_out,
  output logic [31:0] mem_addr_out
);
  // Idle at time zero; data lines hold a pattern rather than zeros so stale data stands out.
  initial begin
    cfg_req_out = '{valid: 1'b0, write: 1'b0, offset: 8'h00, byte_en: 4'h0, wdata: 32'ha5a5a5a5};
    local_rom_range_out = 1'b0;
    mem_valid_out = 1'b0;
    mem_addr_out = 32'h5a5a5a5a;
  end

  // One configuration cycle, entered just after a falling edge.
  // The request is held through the taking edge and the answer is read one cycle later.
  // Valid is left high, so a following call runs back to back.
  task automatic access(input logic wr, input logic [7:0] off, input logic [3:0] be,
                        input logic [31:0] wd, output cfg_rsp_t rsp);
    cfg_req_out.valid = 1'b1;
    cfg_req_out.write = wr;
    cfg_req_out.offset = off;
    cfg_req_out.byte_en = be;
    cfg_req_out.wdata = wd;
    @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    rsp = cfg_rsp_in;
  endtask : access

  // Drops the request and turns the data over, then lets one edge pass before any new call.
  task automatic release_bus();
    cfg_req_out.valid = 1'b0;
    cfg_req_out.byte_en = 4'h0;
    cfg_req_out.wdata = ~cfg_req_out.wdata;
    @(negedge ref_clk_in);
  endtask : release_bus

  // Presents one memory address with the local range bit and returns the claim seen a cycle later.
  // Firmware never gets a ROM window on this part, so a claim is never relied upon.
  task automatic rom_probe(input logic [31:0] addr, input logic range, output logic claim);
    mem_valid_out = 1'b1;
    mem_addr_out = addr;
    local_rom_range_out = range;
    @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    claim = rom_claim_in;
    mem_valid_out = 1'b0;
    mem_addr_out = ~addr;
    @(negedge ref_clk_in);
  endtask : rom_probe
endmodule : cfg_host_model

// >>> pci_config_header_tail_tb_top.sv
// Self-checking testbench for the upper configuration header block.
`timescale 1ns/100ps
module pci_config_header_tail_tb_top;
  import cfg_tail_pkg::*;
  logic ref_clk_in = 1'b0; // Bus clock, 5 ns period.
  logic resetn_in = 1'b0; // Reset starts asserted.
  cfg_req_t cfg_req; // Request from the host model.
  cfg_rsp_t cfg_rsp; // Answer from the block.
  logic range_bit; // Local ROM range bit.
  logic mem_valid; // Memory probe valid.
  logic [31:0] mem_addr; // Memory probe address.
  logic claim; // ROM claim output.
  logic dec_en; // Decode enable output.
  logic [7:0] routing; // Routing byte output.
  logic seen; // Claim returned by a probe.
  int mismatches = 0; // Wrong values seen.
  int n_tests = 0; // Comparisons made.

  // Clock generator.
  always #2.5 ref_clk_in = ~ref_clk_in;

  pci_config_header_tail pci_config_header_tail_i (
    .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .cfg_req_in(cfg_req),
    .cfg_rsp_out(cfg_rsp), .local_rom_range_in(range_bit), .mem_valid_in(mem_valid),
    .mem_addr_in(mem_addr), .rom_claim_out(claim), .rom_decode_enable_out(dec_en),
    .interrupt_routing_out(routing));

  cfg_host_model cfg_host_model_i (
    .ref_clk_in(ref_clk_in), .cfg_rsp_in(cfg_rsp), .rom_claim_in(claim),
    .cfg_req_out(cfg_req), .local_rom_range_out(range_bit), .mem_valid_out(mem_valid),
    .mem_addr_out(mem_addr));

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("checks %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  // Compares a plain value with four-state equality.
  task automatic chk_val(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      mismatches++;
    end
  endtask : chk_val

  // Compares a whole answer: ack must be up, hit and data as given.
  // The answer is wider than a word, so it is compared here rather than through chk_val.
  task automatic chk_rsp(input string name, input logic hit, input logic [31:0] exp,
                         input cfg_rsp_t rsp);
    cfg_rsp_t want;
    want = '{ack: 1'b1, hit: hit, rdata: exp};
    n_tests++;
    if (rsp !== want) begin
      $display("wrong value %s expected %h seen %h", name, want, rsp);
      mismatches++;
    end
  endtask : chk_rsp

  // Configuration read with its expected answer.
  task automatic rd(input logic [7:0] off, input logic hit, input logic [31:0] exp);
    cfg_rsp_t rsp;
    cfg_host_model_i.access(1'b0, off, 4'hf, 32'h0, rsp);
    chk_rsp($sformatf("read_%h", off), hit, exp, rsp);
  endtask : rd

  // Configuration write; the answer carries zero data.
  task automatic wr(input logic [7:0] off, input logic [3:0] be, input logic [31:0] d);
    cfg_rsp_t rsp;
    cfg_host_model_i.access(1'b1, off, be, d, rsp);
    chk_rsp($sformatf("write_%h", off), 1'b1, 32'h0, rsp);
  endtask : wr

  // Watchdog: a hang counts as a mismatch and closes the run.
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    $display("wrong value run_length expected done seen hang");
    mismatches++;
    final_report();
  end

  // Main sequence; inputs move on falling edges only.
  initial begin
    repeat (6) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    resetn_in = 1'b1;
    @(negedge ref_clk_in);
    chk_val("decode_enable", 32'h0, {31'h0, dec_en});
    chk_val("routing_reset", 32'h0, {24'h0, routing});
    rd(8'h30, 1'b1, 32'h00000000);
    rd(8'h34, 1'b1, 32'h00000078);
    rd(8'h38, 1'b1, 32'h00000000);
    rd(8'h3c, 1'b1, 32'h00000100);
    // Back-to-back writes and reads from here on; reserved bits must not stick.
    wr(8'h30, 4'hf, 32'hffffffff);
    rd(8'h30, 1'b1, 32'hfffff800);
    wr(8'h30, 4'h2, 32'h00000000);
    rd(8'h30, 1'b1, 32'hffff0000);
    wr(8'h30, 4'h1, 32'h000007ff);
    rd(8'h30, 1'b1, 32'hffff0000);
    wr(8'h34, 4'hf, 32'hffffffff);
    rd(8'h34, 1'b1, 32'h00000078);
    wr(8'h3c, 4'hf, 32'hffffffff);
    rd(8'h3c, 1'b1, 32'h000001ff);
    wr(8'h3c, 4'he, 32'h00000000);
    rd(8'h3c, 1'b1, 32'h000001ff);
    wr(8'h3c, 4'h1, 32'h0000005a);
    rd(8'h3c, 1'b1, 32'h0000015a);
    chk_val("routing", 32'h5a, {24'h0, routing});
    rd(8'h40, 1'b0, 32'h0);
    rd(8'h2c, 1'b0, 32'h0);
    // A matching base with the range bit on or off must still not be claimed.
    wr(8'h30, 4'hf, 32'h12345800);
    cfg_host_model_i.release_bus();
    cfg_host_model_i.rom_probe(32'h123458a0, 1'b1, seen);
    chk_val("claim_range_on", 32'h0, {31'h0, seen});
    cfg_host_model_i.rom_probe(32'h123458a0, 1'b0, seen);
    chk_val("claim_range_off", 32'h0, {31'h0, seen});
    chk_val("decode_enable_held", 32'h0, {31'h0, dec_en});
    // Second reset in mid-run clears the writable state.
    resetn_in = 1'b0;
    @(negedge ref_clk_in);
    chk_val("routing_in_reset", 32'h0, {24'h0, routing});
    chk_val("answer_in_reset", 32'h0, cfg_rsp[31:0]);
    chk_val("answer_flags_in_reset", 32'h0, {30'h0, cfg_rsp.ack, cfg_rsp.hit});
    resetn_in = 1'b1;
    @(negedge ref_clk_in);
    rd(8'h30, 1'b1, 32'h00000000);
    rd(8'h3c, 1'b1, 32'h00000100);
    cfg_host_model_i.release_bus();
    final_report();
  end
endmodule : pci_config_header_tail_tb_top
